// ==== shared/elm_regs.svh ====
// endian select codes and address munge masks for the lane mapper
`ifndef ELM_REGS_SVH
`define ELM_REGS_SVH
`define ELM_END_BIG     2'h0
`define ELM_END_MUNGED  2'h1
`define ELM_END_LITTLE  2'h2
`define ELM_END_TRUE    2'h3
`define ELM_MUNGE_WORD  3'h4
`define ELM_MUNGE_HALF  3'h6
`define ELM_MUNGE_BYTE  3'h7
`define ELM_MUNGE_NONE  3'h0
`endif

// ==== shared/elm_pkg.sv ====
// types carried between the processor bus, register file and pci side
package elm_pkg;
    typedef logic [1:0] elm_end_t;

    typedef struct packed {
        logic [2:0]  addr;
        logic [2:0]  size;
        logic        burst;
        logic        is_reg;
        logic        launch_pci;
        logic        from_dma;
        elm_end_t    endian;
        logic [63:0] wdata;
    } elm_req_t;

    typedef struct packed {
        logic        word_sel;
        logic [3:0]  byte_en;
        logic [31:0] wdata;
    } elm_reg_acc_t;

    typedef struct packed {
        logic [2:0]  addr;
        logic [7:0]  byte_en;
        logic [63:0] data;
    } elm_pci_acc_t;
endpackage : elm_pkg

// ==== core/elm_mapper.sv ====
// byte lane and address mapper between processor bus, registers and pci
`timescale 1ns/1ps
`include "elm_regs.svh"

module elm_mapper (
    // clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 reset_n,
    // processor bus slave request
    input  wire logic                 req_valid,
    input  wire elm_pkg::elm_req_t    req,
    output logic                      proc_bus_xfer_ack,
    output logic                      proc_bus_xfer_error_n,
    // dma element mode load
    input  wire logic                 dma_elem_load,
    input  wire elm_pkg::elm_end_t    dma_endian,
    // register file and pci write side
    output logic                      reg_strobe,
    output elm_pkg::elm_reg_acc_t     reg_acc,
    output logic                      pci_strobe,
    output elm_pkg::elm_pci_acc_t     pci_acc,
    // read return
    input  wire logic                 tgt_rdata_valid,
    input  wire logic [63:0]          tgt_rdata,
    output logic                      proc_rdata_valid,
    output logic [63:0]               proc_rdata,
    // bridge as processor bus master
    input  wire logic                 mst_req_valid,
    input  wire elm_pkg::elm_req_t    mst_req,
    output logic                      mst_ready,
    output logic                      mst_bus_valid,
    output logic [2:0]                mst_bus_addr,
    output logic [2:0]                mst_bus_size,
    input  wire logic                 mst_bus_ready
);
    import elm_pkg::*;

    typedef enum logic [1:0] {ELM_IDLE, ELM_ISSUE, ELM_SPLIT} elm_mst_st_t;

    logic        rst_meta;
    logic        rst_n;
    elm_end_t    dma_mode;
    elm_end_t    mode;
    logic        munged;
    logic        inv;
    logic        err;
    logic        to_reg;
    logic [7:0]  lanes;
    logic [1:0]  xm;
    logic [63:0] pci_data;
    logic [31:0] reg_data;
    logic [3:0]  reg_be;
    logic [7:0]  pci_be;
    logic [63:0] rd_map;
    logic        cur_munged;
    logic        cur_inv;
    logic        cur_is_reg;
    logic [1:0]  cur_xm;
    logic [7:0]  cur_lanes;
    elm_mst_st_t mst_state;
    logic [2:0]  split_addr;
    logic [3:0]  split_left;
    logic        mst_munged;

    function automatic logic [7:0] elm_lane_mask(input logic [2:0] a,
                                                 input logic [2:0] s);
        logic [3:0] cnt;
        logic [3:0] last;
        logic [7:0] m;
        cnt  = (s == 3'h0) ? 4'h8 : {1'b0, s};
        last = {1'b0, a} + cnt;
        for (int i = 0; i < 8; i++) begin
            m[i] = (4'(i) >= {1'b0, a}) && (4'(i) < last);
        end
        return m;
    endfunction : elm_lane_mask

    function automatic logic elm_be_legal(input logic [2:0] a,
                                          input logic [2:0] s);
        unique case (s)
            3'h1:    return 1'b1;
            3'h2:    return a[1:0] != 2'h3;
            3'h3:    return a[1] == 1'b0;
            3'h4:    return a[1:0] == 2'h0;
            3'h5:    return (a == 3'h0) || (a == 3'h3);
            3'h6:    return (a == 3'h0) || (a == 3'h2);
            3'h7:    return (a == 3'h0) || (a == 3'h1);
            default: return a == 3'h0;
        endcase
    endfunction : elm_be_legal

    function automatic logic elm_mg_legal(input logic [2:0] a,
                                          input logic [2:0] s);
        unique case (s)
            3'h1:    return 1'b1;
            3'h2:    return a[0] == 1'b0;
            3'h4:    return a[1:0] == 2'h0;
            3'h0:    return a == 3'h0;
            default: return 1'b0;
        endcase
    endfunction : elm_mg_legal

    function automatic logic [2:0] elm_mask(input logic [2:0] s);
        unique case (s)
            3'h1:    return `ELM_MUNGE_BYTE;
            3'h2:    return `ELM_MUNGE_HALF;
            3'h4:    return `ELM_MUNGE_WORD;
            default: return `ELM_MUNGE_NONE;
        endcase
    endfunction : elm_mask

    // reset release through two flops
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // dma mode held per direct transfer or list element
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dma_mode <= `ELM_END_BIG;
        end else if (dma_elem_load) begin
            dma_mode <= dma_endian;
        end
    end

    // mode of this access comes from the image or dma channel
    assign mode   = req.from_dma ? dma_mode : req.endian;
    assign munged = mode == `ELM_END_MUNGED;
    assign inv    = (mode == `ELM_END_BIG) || (mode == `ELM_END_TRUE);
    assign to_reg = req.is_reg && !req.launch_pci;
    assign lanes  = elm_lane_mask(req.addr, req.size);
    assign xm     = (req.size == 3'h1) ? 2'h0 :
                    (req.size == 3'h2) ? 2'h1 : 2'h3;
    assign err    = munged ? !elm_mg_legal(req.addr, req.size)
                           : !elm_be_legal(req.addr, req.size);

    // register byte b takes the lane that carries it
    for (genvar b = 0; b < 4; b++) begin : g_reg_byte
        logic [2:0] ln;
        assign ln = {req.addr[2], munged ? (2'(b) ^ xm)
                                         : 2'(3 - b)};
        assign reg_be[b]            = lanes[ln];
        assign reg_data[8*b +: 8]   = req.wdata[8*ln +: 8];
    end

    // pci lane and read return steering per lane
    for (genvar n = 0; n < 8; n++) begin : g_lane
        logic [2:0] src;
        logic [1:0] rb;
        assign src = inv ? 3'(n) : 3'(7 - n);
        assign pci_be[n]          = lanes[src];
        assign pci_data[8*n +: 8] = req.wdata[8*src +: 8];
        assign rb = cur_munged ? (2'(n % 4) ^ cur_xm) : 2'(3 - (n % 4));
        assign rd_map[8*n +: 8] = !cur_lanes[n] ? 8'h00 :
            cur_is_reg ? tgt_rdata[8*rb +: 8]
                       : tgt_rdata[8*(cur_inv ? n : 7 - n) +: 8];
    end

    // slave response one cycle after the request
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            proc_bus_xfer_ack     <= 1'b0;
            proc_bus_xfer_error_n <= 1'b1;
            reg_strobe            <= 1'b0;
            pci_strobe            <= 1'b0;
            reg_acc               <= '0;
            pci_acc               <= '0;
        end else begin
            proc_bus_xfer_ack     <= req_valid && !err;
            proc_bus_xfer_error_n <= !(req_valid && err);
            reg_strobe            <= req_valid && !err && to_reg;
            pci_strobe            <= req_valid && !err && !to_reg;
            if (req_valid && !err) begin
                reg_acc.word_sel <= munged ? !req.addr[2]
                                           : req.addr[2];
                reg_acc.byte_en  <= reg_be;
                reg_acc.wdata    <= reg_data;
                pci_acc.addr     <= (munged && !req.burst)
                                    ? req.addr ^ elm_mask(req.size)
                                    : req.addr;
                pci_acc.byte_en  <= pci_be;
                pci_acc.data     <= pci_data;
            end
        end
    end

    // context kept for the read return
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_munged <= 1'b0;
            cur_inv    <= 1'b1;
            cur_is_reg <= 1'b0;
            cur_xm     <= 2'h0;
            cur_lanes  <= 8'h00;
        end else if (req_valid && !err) begin
            cur_munged <= munged;
            cur_inv    <= inv;
            cur_is_reg <= to_reg;
            cur_xm     <= xm;
            cur_lanes  <= lanes;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            proc_rdata_valid <= 1'b0;
            proc_rdata       <= 64'h0000_0000_0000_0000;
        end else begin
            proc_rdata_valid <= tgt_rdata_valid;
            if (tgt_rdata_valid) begin
                proc_rdata <= rd_map;
            end
        end
    end

    // bridge as processor bus master
    assign mst_ready  = mst_state == ELM_IDLE;
    assign mst_munged = mst_req.endian == `ELM_END_MUNGED;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mst_state     <= ELM_IDLE;
            mst_bus_valid <= 1'b0;
            mst_bus_addr  <= 3'h0;
            mst_bus_size  <= 3'h0;
            split_addr    <= 3'h0;
            split_left    <= 4'h0;
        end else begin
            unique case (mst_state)
                ELM_IDLE: if (mst_req_valid) begin
                    mst_bus_valid <= 1'b1;
                    if (mst_munged && !mst_req.burst &&
                        !elm_mg_legal(mst_req.addr, mst_req.size)) begin
                        mst_state    <= ELM_SPLIT;
                        mst_bus_addr <= mst_req.addr ^ `ELM_MUNGE_BYTE;
                        mst_bus_size <= 3'h1;
                        split_addr   <= mst_req.addr;
                        split_left   <= (mst_req.size == 3'h0) ? 4'h8
                                        : {1'b0, mst_req.size};
                    end else begin
                        mst_state    <= ELM_ISSUE;
                        mst_bus_addr <= (mst_munged && !mst_req.burst)
                            ? mst_req.addr ^ elm_mask(mst_req.size)
                            : mst_req.addr;
                        mst_bus_size <= mst_req.size;
                    end
                end
                ELM_ISSUE: if (mst_bus_ready) begin
                    mst_bus_valid <= 1'b0;
                    mst_state     <= ELM_IDLE;
                end
                ELM_SPLIT: if (mst_bus_ready) begin
                    if (split_left == 4'h1) begin
                        mst_bus_valid <= 1'b0;
                        mst_state     <= ELM_IDLE;
                    end else begin
                        split_addr   <= split_addr + 3'h1;
                        split_left   <= split_left - 4'h1;
                        mst_bus_addr <= (split_addr + 3'h1) ^ `ELM_MUNGE_BYTE;
                    end
                end
                default: mst_state <= ELM_IDLE;
            endcase
        end
    end

    // checks
    ack_one_cycle_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        req_valid |=> (proc_bus_xfer_ack == proc_bus_xfer_error_n))
        else $error("no single answer one cycle after request");
    odd_half_err_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        req_valid && munged && req.size == 3'h2 && req.addr[0]
        |=> !proc_bus_xfer_error_n && !reg_strobe && !pci_strobe)
        else $error("odd munged halfword not refused");
    word_select_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        req_valid && to_reg && munged && !err
        |=> reg_strobe && reg_acc.word_sel == !$past(req.addr[2]))
        else $error("munged register word select wrong");
    byte_lane_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        req_valid && to_reg && munged && req.size == 3'h1
        |=> reg_acc.byte_en == 4'(1 << $past(req.addr[1:0])))
        else $error("munged byte lane not at n mod 4");
    half_order_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        req_valid && to_reg && munged && req.size == 3'h2
        && req.addr[1:0] == 2'h0 |=> reg_acc.byte_en == 4'h3
        && reg_acc.wdata[15:8] == $past(req.addr[2] ? req.wdata[39:32]
                                                    : req.wdata[7:0]))
        else $error("munged halfword lane order wrong");
    big_invariant_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        req_valid && !to_reg && mode == `ELM_END_BIG && !err
        |=> pci_acc.data == $past(req.wdata) && pci_acc.byte_en == $past(lanes))
        else $error("big mode not address invariant");
    big_start_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        req_valid && mode == `ELM_END_BIG && req.size == 3'h5
        && req.addr == 3'h1 |=> !proc_bus_xfer_error_n)
        else $error("illegal big start accepted");
    mst_munge_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        mst_ready && mst_req_valid && mst_munged && !mst_req.burst
        && mst_req.size == 3'h4 && mst_req.addr == 3'h0
        |=> mst_bus_valid && mst_bus_addr == 3'h4)
        else $error("outgoing word address not munged");
    mst_split_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        mst_ready && mst_req_valid && mst_munged && !mst_req.burst
        && mst_req.size == 3'h4 && mst_req.addr == 3'h2
        |=> mst_bus_size == 3'h1 && mst_bus_addr == 3'h5)
        else $error("unaligned master request not split");
    munged_word_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
        req_valid && to_reg && munged && req.size == 3'h4 && !err);
    pci_launch_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
        req_valid && req.is_reg && req.launch_pci);
    split_done_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
        mst_state == ELM_SPLIT ##1 mst_state == ELM_IDLE);
endmodule : elm_mapper

// ==== test/elm_core_model.sv ====
// processor core model answering the bridge's outgoing bus cycles
`timescale 1ns/1ps
module elm_core_model (
    // clock
    input  wire logic       sys_clk,
    // outgoing cycle from the bridge
    input  wire logic       mst_bus_valid,
    input  wire logic [2:0] mst_bus_addr,
    input  wire logic [2:0] mst_bus_size,
    output logic            mst_bus_ready,
    // answer delay in cycles
    input  wire logic [3:0] lag
);
    logic [2:0] seen_addr [0:15];
    logic [2:0] seen_size [0:15];
    int         n_seen = 0;
    logic       took   = 1'b0;
    logic [3:0] wcnt   = 4'h0;
    initial mst_bus_ready = 1'b0;
    // log each cycle taken
    always @(posedge sys_clk) begin
        took <= mst_bus_valid && mst_bus_ready;
        if (mst_bus_valid && mst_bus_ready) begin
            seen_addr[n_seen[3:0]] <= mst_bus_addr;
            seen_size[n_seen[3:0]] <= mst_bus_size;
            n_seen <= n_seen + 1;
        end
    end
    // ready after lag cycles, dropped once a cycle is taken
    always @(negedge sys_clk) begin
        if (took || !mst_bus_valid) begin
            mst_bus_ready <= 1'b0;
            wcnt <= 4'h0;
        end else if (wcnt >= lag) begin
            mst_bus_ready <= 1'b1;
        end else begin
            wcnt <= wcnt + 4'h1;
        end
    end
endmodule : elm_core_model

// ==== test/tb_endian_byte_lane_mapper.sv ====
// testbench for the byte lane mapper
`timescale 1ns/1ps
`include "elm_regs.svh"
module tb_endian_byte_lane_mapper;
    import elm_pkg::*;
    localparam logic [63:0] PAT = 64'hA7A6_A5A4_A3A2_A1A0;
    localparam logic [63:0] REV = 64'hA0A1_A2A3_A4A5_A6A7;
    logic         sys_clk = 1'b0, reset_n = 1'b0, req_valid = 1'b0;
    elm_req_t     req = '0, mst_req = '0;
    logic         dma_elem_load = 1'b0, tgt_rdata_valid = 1'b0;
    elm_end_t     dma_endian = 2'h0;
    logic [63:0]  tgt_rdata = 64'h0, proc_rdata;
    logic         mst_req_valid = 1'b0, mst_bus_ready, mst_ready;
    logic [3:0]   lag = 4'h0;
    logic         ack, err_n, reg_strobe, pci_strobe, proc_rdata_valid;
    logic         mst_bus_valid;
    logic [2:0]   mst_bus_addr, mst_bus_size;
    elm_reg_acc_t reg_acc;
    elm_pci_acc_t pci_acc;
    int           n_fail = 0, checks = 0, base;
    always #5 sys_clk = ~sys_clk;
    elm_mapper i_elm_mapper (.sys_clk(sys_clk), .reset_n(reset_n),
        .req_valid(req_valid), .req(req), .proc_bus_xfer_ack(ack),
        .proc_bus_xfer_error_n(err_n), .dma_elem_load(dma_elem_load),
        .dma_endian(dma_endian), .reg_strobe(reg_strobe),
        .reg_acc(reg_acc), .pci_strobe(pci_strobe), .pci_acc(pci_acc),
        .tgt_rdata_valid(tgt_rdata_valid), .tgt_rdata(tgt_rdata),
        .proc_rdata_valid(proc_rdata_valid), .proc_rdata(proc_rdata),
        .mst_req_valid(mst_req_valid), .mst_req(mst_req),
        .mst_ready(mst_ready), .mst_bus_valid(mst_bus_valid),
        .mst_bus_addr(mst_bus_addr), .mst_bus_size(mst_bus_size),
        .mst_bus_ready(mst_bus_ready));
    elm_core_model i_elm_core_model (.sys_clk(sys_clk),
        .mst_bus_valid(mst_bus_valid), .mst_bus_addr(mst_bus_addr),
        .mst_bus_size(mst_bus_size), .mst_bus_ready(mst_bus_ready),
        .lag(lag));
    task chk(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk
    task tally_and_finish;
        if (n_fail == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish
    // one slave request; returns in the cycle the answer stands
    task send(input elm_end_t e, input logic [2:0] s, input logic [2:0] a,
              input logic r, input logic l, input logic b, input logic d);
        @(negedge sys_clk);
        req = '{addr:a, size:s, burst:b, is_reg:r, launch_pci:l,
                from_dma:d, endian:e, wdata:PAT};
        req_valid = 1'b1;
        @(negedge sys_clk);
        req_valid = 1'b0;
    endtask : send
    // one master request, waits until n cycles went out and idle again
    task mreq(input elm_end_t e, input logic [2:0] s, input logic [2:0] a,
              input logic b, input int n);
        int i;
        base = i_elm_core_model.n_seen;
        @(negedge sys_clk);
        mst_req = '{addr:a, size:s, burst:b, is_reg:1'b0, launch_pci:1'b0,
                    from_dma:1'b0, endian:e, wdata:PAT};
        mst_req_valid = 1'b1;
        @(negedge sys_clk);
        mst_req_valid = 1'b0;
        for (i = 0; i < 100 && !(i_elm_core_model.n_seen == base + n
             && mst_ready === 1'b1); i++) @(negedge sys_clk);
        if (i == 100) begin
            chk(1'b0, 1'b1);
            tally_and_finish();
        end
    endtask : mreq
    task t_reset;
        chk(mst_ready, 1'b1);
        chk({err_n, ack, reg_strobe, pci_strobe}, 4'h8);
    endtask : t_reset
    task t_reg_bytes;
        for (int a = 0; a < 8; a++) begin
            send(`ELM_END_MUNGED, 3'h1, a[2:0], 1, 0, 0, 0);
            chk({ack, reg_strobe}, 2'h3);
            chk(reg_acc.word_sel, a < 4);
            chk(reg_acc.byte_en, 4'h1 << (a % 4));
            chk(reg_acc.wdata[8*(a%4) +: 8], 8'hA0 + a);
        end
    endtask : t_reg_bytes
    task t_reg_wide;
        send(`ELM_END_MUNGED, 3'h2, 3'h0, 1, 0, 0, 0);
        chk({reg_acc.word_sel, reg_acc.byte_en}, 5'h13);
        chk(reg_acc.wdata[15:0], 16'hA0A1);
        send(`ELM_END_MUNGED, 3'h2, 3'h6, 1, 0, 0, 0);
        chk({reg_acc.word_sel, reg_acc.byte_en}, 5'h0C);
        chk(reg_acc.wdata[31:16], 16'hA6A7);
        send(`ELM_END_MUNGED, 3'h4, 3'h0, 1, 0, 0, 0);
        chk(reg_acc.wdata, 32'hA0A1_A2A3);
    endtask : t_reg_wide
    // nibbles: error, mode, size, address
    task t_errors;
        logic [15:0] tbl [0:16] = '{16'h1130, 16'h1150, 16'h1160,
            16'h1170, 16'h1121, 16'h1142, 16'h1101, 16'h1023, 16'h1051,
            16'h1032, 16'h0025, 16'h0053, 16'h0062, 16'h0071, 16'h0000,
            16'h0035, 16'h0144};
        for (int k = 0; k < 17; k++) begin
            send(tbl[k][9:8], tbl[k][6:4], tbl[k][2:0], 1, 0, 0, 0);
            chk(err_n, !tbl[k][12]);
            chk({ack, reg_strobe}, tbl[k][12] ? 2'h0 : 2'h3);
        end
    endtask : t_errors
    task t_pci;
        send(`ELM_END_BIG, 3'h0, 3'h0, 0, 0, 0, 0);
        chk({pci_strobe, pci_acc.byte_en}, 9'h1FF);
        chk(pci_acc.data, PAT);
        send(`ELM_END_TRUE, 3'h0, 3'h0, 0, 0, 0, 0);
        chk(pci_acc.data, PAT);
        send(`ELM_END_LITTLE, 3'h0, 3'h0, 0, 0, 0, 0);
        chk(pci_acc.data, REV);
        send(`ELM_END_BIG, 3'h2, 3'h1, 0, 0, 0, 0);
        chk({pci_acc.addr, pci_acc.byte_en}, 11'h106);
        send(`ELM_END_MUNGED, 3'h1, 3'h0, 0, 0, 0, 0);
        chk({pci_acc.addr, pci_acc.byte_en}, 11'h780);
        chk(pci_acc.data[63:56], 8'hA0);
        send(`ELM_END_MUNGED, 3'h4, 3'h0, 0, 0, 1, 0);
        chk(pci_acc.addr, 3'h0);
        send(`ELM_END_MUNGED, 3'h2, 3'h0, 1, 1, 0, 0);
        chk({pci_strobe, pci_acc.addr}, 4'hE);
        send(`ELM_END_BIG, 3'h4, 3'h4, 0, 0, 0, 0);
        @(negedge sys_clk);
        tgt_rdata = PAT;
        tgt_rdata_valid = 1'b1;
        @(negedge sys_clk);
        tgt_rdata_valid = 1'b0;
        chk(proc_rdata_valid, 1'b1);
        chk(proc_rdata, 64'hA7A6_A5A4_0000_0000);
    endtask : t_pci
    task t_dma(input elm_end_t m, input elm_end_t img, input logic [63:0] x);
        @(negedge sys_clk);
        dma_endian = m;
        dma_elem_load = 1'b1;
        @(negedge sys_clk);
        dma_elem_load = 1'b0;
        send(img, 3'h0, 3'h0, 0, 0, 0, 1);
        chk(pci_acc.data, x);
    endtask : t_dma
    task t_master;
        lag = 4'h2;
        mreq(`ELM_END_MUNGED, 3'h4, 3'h2, 0, 4);
        for (int k = 0; k < 4; k++) begin
            chk(i_elm_core_model.seen_addr[base+k], 3'h5 - k);
            chk(i_elm_core_model.seen_size[base+k], 3'h1);
        end
        lag = 4'h0;
        mreq(`ELM_END_MUNGED, 3'h4, 3'h4, 0, 1);
        chk(i_elm_core_model.seen_addr[base], 3'h0);
        chk(i_elm_core_model.seen_size[base], 3'h4);
        mreq(`ELM_END_MUNGED, 3'h4, 3'h4, 1, 1);
        chk(i_elm_core_model.seen_addr[base], 3'h4);
    endtask : t_master
    initial begin
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk);
        reset_n = 1'b1;
        repeat (3) @(posedge sys_clk);
        t_reset();
        t_reg_bytes();
        t_reg_wide();
        t_errors();
        t_pci();
        t_dma(`ELM_END_LITTLE, `ELM_END_BIG, REV);
        t_dma(`ELM_END_BIG, `ELM_END_LITTLE, PAT);
        t_master();
        tally_and_finish();
    end
endmodule : tb_endian_byte_lane_mapper
